// *** hw/ans_pin_sync.sv ***
`timescale 1ns/1ns
// Three-stage synchroniser; the output moves only when stages two and three
// agree, which filters a single-cycle glitch that slipped past stage one.
module ans_pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } ans_sync_s;

  ans_sync_s st_q;
  ans_sync_s st_d;

  // Refuse a zero-width synchroniser.
  if (W < 1) begin : g_bad_w
    $error("ans_pin_sync needs a width of at least one.");
  end

  // Shift the pins in; accept a change once two stages agree.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < int'(W); i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_sync = st_q.out;

endmodule

// *** hw/ans_regs.sv ***
`timescale 1ns/1ns
// Function
// - Identifier word: OUI bits 19-24 on top, model in 9:4, revision low.
// - Revision field resets to the silicon revision, not a fixed value.
// - Next-page advert bit is writable, resets zero, never enables pages.
// - Writable asymmetric pause in bit 11 and symmetric pause in bit 10.
// - Four speed/duplex advert bits reset from the two mode straps.
// - Symmetric pause advert resets from the single pause strap pin.
// - Selector resets to 802.3 code in both advert and partner words.
// - Partner ability read-only, resets to 0001h, acknowledge set on arrival.
// - Partner ability bit 10 reports the remote pause support.
// - Partner bit 9 shows T4 ability; the device never runs T4.
// - Expansion bit 4 latches a parallel detection fault until read.
// - Expansion bit 1 latches every newly received page until read.
// - Expansion bits 3 and 0 give partner next-page and AN ability.
// - Expansion bit 2, local next-page ability, is read-only zero.
// - Next page transmit: message-page resets one, code field resets one.
// - Toggle bit is read-only, the inverse of the previous toggle.
// - Bit 12 of next page words says the device will comply.
// - Next page receive is a read-only mirror; message-page resets set.
// - With negotiation enabled, manual speed and duplex are ignored.
module ans_regs #(
  parameter logic [5:0] OUI_BITS = 6'h2A, // Arbitrary value.
  parameter logic [5:0] MODEL_NUM = 6'h15, // Arbitrary value.
  parameter logic [3:0] SILICON_REV = 4'h1 // Arbitrary value.
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ans_pkg::ans_avm_req_s avm_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] mode_strap_pins,
  input wire logic pause_strap_pin,
  input wire logic sw_reset,
  input wire ans_pkg::ans_page_s base_page,
  input wire ans_pkg::ans_page_s next_page,
  input wire logic np_tx_sent,
  input wire logic pd_fault,
  input wire logic partner_an_able,
  input wire logic an_enable,
  input wire ans_pkg::ans_mode_s manual_mode,
  input wire ans_pkg::ans_mode_s negotiated_mode,
  output ans_pkg::ans_mode_s active_mode,
  output logic [15:0] adv_word,
  output logic [15:0] np_tx_word
);

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic [2:0] strap_cnt;
    logic strap_done;
    logic [15:0] id;
    logic [15:0] adv;
    logic [15:0] lp;
    logic pdf;
    logic prx;
    logic lp_an;
    logic [15:0] nptx;
    logic toggle;
    logic [15:0] nprx;
    ans_pkg::ans_mode_s mode;
  } ans_regs_s;

  ans_regs_s st_q;
  ans_regs_s st_d;
  logic [2:0] strap_sync;
  logic req;
  logic [5:0] idx;
  logic [15:0] wr_id;
  logic [15:0] wr_adv;
  logic [15:0] wr_nptx;

  // The six-bit word index is cut from an eight-bit byte address.
  if (ans_pkg::ADDR_W != 8) begin : g_bad_addr
    $error("ans_regs needs an eight-bit byte address.");
  end

  // Merges a write under byte enables, touching only writable bits.
  function automatic logic [15:0] be_merge(
    input logic [15:0] old_v,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [15:0] wmask
  );
    logic [15:0] new_v;
    new_v[7:0] = be[0] ? wdata[7:0] : old_v[7:0];
    new_v[15:8] = be[1] ? wdata[15:8] : old_v[15:8];
    return (new_v & wmask) | (old_v & ~wmask);
  endfunction

  // Maps the two mode straps to the 100FD, 100, 10FD and 10 ability bits.
  function automatic logic [3:0] strap_abilities(input logic [1:0] mode);
    logic [3:0] ab;
    ab = 4'h0;
    case (mode)
      2'h0: ab = 4'h1;
      2'h1: ab = 4'h3;
      2'h2: ab = 4'hC;
      2'h3: ab = 4'hF;
      default: ab = 4'hF;
    endcase
    return ab;
  endfunction

  // Assembles the read value of one register index.
  function automatic logic [15:0] read_value(
    input ans_regs_s s,
    input logic [5:0] i
  );
    logic [15:0] v;
    v = 16'h0000;
    case (i)
      ans_pkg::IDX_ID_LOW: v = s.id;
      ans_pkg::IDX_ADV: v = s.adv & ans_pkg::ADV_WMASK;
      ans_pkg::IDX_LP: v = s.lp & ans_pkg::LP_MASK;
      ans_pkg::IDX_EXP: begin
        v[ans_pkg::EXP_PDF] = s.pdf;
        v[ans_pkg::EXP_LPNP] = s.lp[ans_pkg::AB_NP];
        v[ans_pkg::EXP_NPA] = 1'b0;
        v[ans_pkg::EXP_PRX] = s.prx;
        v[ans_pkg::EXP_LPAN] = s.lp_an;
      end
      ans_pkg::IDX_NPTX: begin
        v = s.nptx & ans_pkg::NPTX_WMASK;
        v[ans_pkg::NP_TOGGLE] = s.toggle;
      end
      ans_pkg::IDX_NPRX: v = s.nprx;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Mode and pause straps come from pins and are synchronised first.
  ans_pin_sync #(
    .W(3)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_async({pause_strap_pin, mode_strap_pins}),
    .pin_sync(strap_sync)
  );

  // Bus decode; the low two address bits select bytes and are ignored.
  assign req = avm_req.avs_read | avm_req.avs_write;
  assign idx = avm_req.avs_address[ans_pkg::ADDR_W-1:2];

  // Candidate write values for the writable registers.
  assign wr_id = be_merge(st_q.id, avm_req.avs_writedata,
                          avm_req.avs_byteenable, ans_pkg::ID_WMASK);
  assign wr_adv = be_merge(st_q.adv, avm_req.avs_writedata,
                           avm_req.avs_byteenable, ans_pkg::ADV_WMASK);
  assign wr_nptx = be_merge(st_q.nptx, avm_req.avs_writedata,
                            avm_req.avs_byteenable, ans_pkg::NPTX_WMASK);

  // Next-state logic of the whole register set.
  always_comb begin
    logic rd_exp;
    rd_exp = 1'b0;
    st_d = st_q;

    // A request is answered one cycle after it is first seen, once the
    // straps have been loaded; the answer cycle ends the handshake.
    st_d.ack = req & ~st_q.ack & st_q.strap_done;
    if (req & ~st_q.ack & st_q.strap_done) begin
      st_d.rdata = avm_req.avs_read ? read_value(st_q, idx) : 16'h0000;
    end

    // Writes take effect at the edge that ends the answer cycle.
    if (st_q.ack & avm_req.avs_write) begin
      case (idx)
        ans_pkg::IDX_ID_LOW: st_d.id = wr_id;
        ans_pkg::IDX_ADV: st_d.adv = wr_adv;
        ans_pkg::IDX_NPTX: st_d.nptx = wr_nptx;
        default: st_d.id = st_q.id;
      endcase
    end
    rd_exp = st_q.ack & avm_req.avs_read & (idx == ans_pkg::IDX_EXP);

    // Latched flags: only bits the read returned are cleared, and a new
    // event in the same cycle wins over the clear.
    st_d.pdf = (st_q.pdf & ~(rd_exp & st_q.rdata[ans_pkg::EXP_PDF]))
               | pd_fault;
    st_d.prx = (st_q.prx & ~(rd_exp & st_q.rdata[ans_pkg::EXP_PRX]))
               | base_page.valid | next_page.valid;
    st_d.lp_an = partner_an_able;

    // Partner base page: reserved bit 12 and asymmetric pause bit 11 dropped, acknowledge forced on.
    if (base_page.valid) begin
      st_d.lp = base_page.word & ans_pkg::LP_MASK;
      st_d.lp[ans_pkg::AB_ACK] = 1'b1;
    end

    // Partner next page is mirrored whole.
    if (next_page.valid) begin
      st_d.nprx = next_page.word;
    end

    // Each transmitted next page flips the toggle that the next one carries.
    if (np_tx_sent) begin
      st_d.toggle = ~st_q.toggle;
    end

    // Straps are applied once the synchroniser has settled after reset.
    if (!st_q.strap_done) begin
      if (st_q.strap_cnt == ans_pkg::STRAP_SETTLE) begin
        st_d.strap_done = 1'b1;
        {st_d.adv[ans_pkg::AB_100FD], st_d.adv[ans_pkg::AB_100],
         st_d.adv[ans_pkg::AB_10FD], st_d.adv[ans_pkg::AB_10]} =
          strap_abilities(strap_sync[1:0]);
        st_d.adv[ans_pkg::AB_PAUSE] = strap_sync[2];
      end else begin
        st_d.strap_cnt = st_q.strap_cnt + 3'h1;
      end
    end

    // Negotiated result overrides manual speed and duplex; T4 never used.
    if (an_enable) begin
      st_d.mode = negotiated_mode;
    end else begin
      st_d.mode = manual_mode;
    end
    if (st_d.mode.speed > ans_pkg::SPD_1000) begin
      st_d.mode.speed = ans_pkg::SPD_10;
    end

    // Software reset returns every register to its reset value and
    // samples the straps again.
    if (sw_reset) begin
      st_d.strap_cnt = 3'h0;
      st_d.strap_done = 1'b0;
      st_d.id = {OUI_BITS, MODEL_NUM, SILICON_REV};
      st_d.adv = ans_pkg::ADV_RST;
      st_d.lp = ans_pkg::LP_RST;
      st_d.pdf = 1'b0;
      st_d.prx = 1'b0;
      st_d.lp_an = 1'b0;
      st_d.nptx = ans_pkg::NPTX_RST;
      st_d.toggle = 1'b0;
      st_d.nprx = ans_pkg::NPRX_RST;
    end
  end

  // State register; straps load later, so reset takes constants only.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q.ack <= 1'b0;
      st_q.rdata <= 16'h0000;
      st_q.strap_cnt <= 3'h0;
      st_q.strap_done <= 1'b0;
      st_q.id <= {OUI_BITS, MODEL_NUM, SILICON_REV};
      st_q.adv <= ans_pkg::ADV_RST;
      st_q.lp <= ans_pkg::LP_RST;
      st_q.pdf <= 1'b0;
      st_q.prx <= 1'b0;
      st_q.lp_an <= 1'b0;
      st_q.nptx <= ans_pkg::NPTX_RST;
      st_q.toggle <= 1'b0;
      st_q.nprx <= ans_pkg::NPRX_RST;
      st_q.mode <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus outputs: wait until the answer cycle; data sit in the low half.
  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = {16'h0000, st_q.rdata};

  // Words handed to the negotiation engine; next pages are never offered.
  assign adv_word = {1'b0, st_q.adv[14:0] & ans_pkg::ADV_WMASK[14:0]};
  assign np_tx_word = {st_q.nptx[15:12], st_q.toggle, st_q.nptx[10:0]};
  assign active_mode = st_q.mode;

endmodule

// *** shared/ans_pkg.sv ***
package ans_pkg;

  // Register word indices; the byte address is four times the index.
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_ID_LOW = 6'h03;
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_LP = 6'h05;
  localparam logic [5:0] IDX_EXP = 6'h06;
  localparam logic [5:0] IDX_NPTX = 6'h07;
  localparam logic [5:0] IDX_NPRX = 6'h08;

  // Identifier field positions.
  localparam int unsigned ID_OUI_LSB = 10;
  localparam int unsigned ID_MODEL_LSB = 4;

  // Advertisement and partner ability bit positions.
  localparam int unsigned AB_NP = 15;
  localparam int unsigned AB_ACK = 14;
  localparam int unsigned AB_ASYM = 11;
  localparam int unsigned AB_PAUSE = 10;
  localparam int unsigned AB_T4 = 9;
  localparam int unsigned AB_100FD = 8;
  localparam int unsigned AB_100 = 7;
  localparam int unsigned AB_10FD = 6;
  localparam int unsigned AB_10 = 5;

  // Expansion register bit positions.
  localparam int unsigned EXP_PDF = 4;
  localparam int unsigned EXP_LPNP = 3;
  localparam int unsigned EXP_NPA = 2;
  localparam int unsigned EXP_PRX = 1;
  localparam int unsigned EXP_LPAN = 0;

  // Next page register bit positions.
  localparam int unsigned NP_ACK2 = 12;
  localparam int unsigned NP_TOGGLE = 11;

  // Writable bit masks and the partner kept-bit mask; every other bit is reserved or read-only.
  localparam logic [15:0] ID_WMASK = 16'hFFFF;
  localparam logic [15:0] ADV_WMASK = 16'hADFF;
  localparam logic [15:0] LP_MASK = 16'hE7FF;
  localparam logic [15:0] NPTX_WMASK = 16'hB7FF;

  // Reset values.
  localparam logic [15:0] ADV_RST = 16'h0001;
  localparam logic [15:0] LP_RST = 16'h0001;
  localparam logic [15:0] NPTX_RST = 16'h2001;
  localparam logic [15:0] NPRX_RST = 16'h2000;

  // Cycles after reset release before the synchronised straps are trusted.
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // Speed codes of the resolved operating mode.
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // Avalon-MM request from the management master.
  typedef struct packed {
    logic avs_read;
    logic avs_write;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
  } ans_avm_req_s;

  // One page word delivered by the negotiation engine.
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } ans_page_s;

  // Speed and duplex of an operating mode.
  typedef struct packed {
    logic [1:0] speed;
    logic duplex;
  } ans_mode_s;

endpackage

// *** verif/ans_link_partner.sv ***
`timescale 1ns/1ns
// Remote partner handing pages to the block, each valid for one cycle.
module ans_link_partner (
  input wire logic clk_sys,
  output ans_pkg::ans_page_s base_page,
  output ans_pkg::ans_page_s next_page
);
  // Idle words show the inverse of the last page so nothing stale lingers.
  initial begin
    base_page = '0;
    next_page = '0;
  end
  task automatic send(input logic nxt, input logic [15:0] w);
    if (nxt) next_page <= '{1'b1, w};
    else base_page <= '{1'b1, w};
    @(posedge clk_sys);
    if (nxt) next_page <= '{1'b0, ~w};
    else base_page <= '{1'b0, ~w};
  endtask
endmodule

// *** verif/ans_regs_properties.sv ***
`timescale 1ns/1ns
// Watches the bus handshake, the derived words and the mode selection.
module ans_regs_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ans_pkg::ans_avm_req_s avm_req,
  input wire logic avs_waitrequest,
  input wire logic np_tx_sent,
  input wire logic sw_reset,
  input wire logic an_enable,
  input wire ans_pkg::ans_mode_s manual_mode,
  input wire ans_pkg::ans_mode_s negotiated_mode,
  input wire ans_pkg::ans_mode_s active_mode,
  input wire logic [15:0] adv_word,
  input wire logic [15:0] np_tx_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic rw;
  ans_pkg::ans_mode_s sel;
  // Request level and the mode the block ought to pick.
  assign rw = avm_req.avs_read | avm_req.avs_write;
  assign sel = an_enable ? negotiated_mode : manual_mode;
  sequence s_wait; rw && avs_waitrequest; endsequence
  sequence s_done; rw && !avs_waitrequest; endsequence
  sequence s_wr_at(logic [5:0] i);
    avm_req.avs_write && !avs_waitrequest && avm_req.avs_address[7:2] == i
      && avm_req.avs_byteenable[1:0] == 2'b11;
  endsequence
  property p_bound; s_wait |-> ##[1:12] !avs_waitrequest; endproperty
  property p_gap; s_done ##1 rw |-> avs_waitrequest; endproperty
  property p_np_off; adv_word[15] == 1'b0; endproperty
  property p_adv_rsv; adv_word[14] == 1'b0 && adv_word[12] == 1'b0
    && adv_word[9] == 1'b0; endproperty
  property p_adv_wr; s_wr_at(ans_pkg::IDX_ADV) |=> adv_word ==
    ($past(avm_req.avs_writedata[15:0]) & ans_pkg::ADV_WMASK & 16'h7FFF);
  endproperty
  property p_nptx_wr; s_wr_at(ans_pkg::IDX_NPTX) |=>
    (np_tx_word & ans_pkg::NPTX_WMASK) ==
    ($past(avm_req.avs_writedata[15:0]) & ans_pkg::NPTX_WMASK);
  endproperty
  property p_toggle; 1'b1 |=> np_tx_word[11] == ($past(sw_reset) ? 1'b0
    : ($past(np_tx_word[11]) ^ $past(np_tx_sent)));
  endproperty
  property p_mode; !$past(rst) |-> active_mode.duplex == $past(sel.duplex)
    && active_mode.speed ==
    (($past(sel.speed) == 2'h3) ? 2'h0 : $past(sel.speed));
  endproperty
  a_bound: assert property (p_bound)
    else $error("waitrequest held too long");
  a_gap: assert property (p_gap)
    else $error("no wait cycle between transfers");
  a_np_off: assert property (p_np_off)
    else $error("next page advertised");
  a_adv_rsv: assert property (p_adv_rsv)
    else $error("reserved advert bit set");
  a_adv_wr: assert property (p_adv_wr)
    else $error("advert word differs from write");
  a_nptx_wr: assert property (p_nptx_wr)
    else $error("next page word differs from write");
  a_toggle: assert property (p_toggle)
    else $error("toggle bit wrong");
  a_mode: assert property (p_mode)
    else $error("active mode wrong");
endmodule

bind ans_regs ans_regs_checker chk (.clk_sys(clk_sys), .rst(rst),
  .avm_req(avm_req), .avs_waitrequest(avs_waitrequest),
  .np_tx_sent(np_tx_sent), .sw_reset(sw_reset), .an_enable(an_enable),
  .manual_mode(manual_mode), .negotiated_mode(negotiated_mode),
  .active_mode(active_mode), .adv_word(adv_word), .np_tx_word(np_tx_word));

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
// Drives the register bus, the partner pages and the mode inputs.
module tb_top;
  localparam logic [5:0] OUI_T = 6'h2D; // Arbitrary value.
  localparam logic [5:0] MODEL_T = 6'h0B; // Arbitrary value.
  localparam logic [3:0] REV_T = 4'h3; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  ans_pkg::ans_avm_req_s req = '{1'b0, 1'b0, 8'h00, 32'h0000_0000, 4'h3};
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] straps = 2'h0;
  logic pause_pin = 1'b0;
  ans_pkg::ans_page_s base_page, next_page;
  logic np_tx_sent = 1'b0;
  logic sw_rst = 1'b0;
  logic pd_fault = 1'b0;
  logic an_able = 1'b0;
  logic an_enable = 1'b0;
  ans_pkg::ans_mode_s man_m = '0, neg_m = '0, act_m;
  logic [15:0] lf = 16'h0051;
  logic [15:0] exp_q [3:8];
  logic [15:0] rd, w, e;
  int mismatches = 0;
  int num_checks = 0;

  ans_regs #(.OUI_BITS(OUI_T), .MODEL_NUM(MODEL_T),
    .SILICON_REV(REV_T)) dut (
    .clk_sys(clk_sys), .rst(rst), .avm_req(req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mode_strap_pins(straps), .pause_strap_pin(pause_pin), .sw_reset(sw_rst),
    .base_page(base_page), .next_page(next_page), .np_tx_sent(np_tx_sent),
    .pd_fault(pd_fault), .partner_an_able(an_able), .an_enable(an_enable),
    .manual_mode(man_m), .negotiated_mode(neg_m), .active_mode(act_m),
    .adv_word(), .np_tx_word());
  ans_link_partner lp (.clk_sys(clk_sys), .base_page(base_page),
    .next_page(next_page));

  // Clock toggles every half period.
  always #5 clk_sys = ~clk_sys;

  // Steps the random source and feeds it to the mode inputs.
  always @(posedge clk_sys) begin
    lf <= {lf[14:0], 1'b0} ^ (lf[15] ? 16'h100B : 16'h0000);
    an_enable <= lf[0];
    man_m <= lf[3:1];
    neg_m <= lf[6:4];
  end

  function automatic logic [15:0] adv_rst(input logic [1:0] m, input logic p);
    logic [3:0] ab;
    ab = (m == 2'h0) ? 4'h1 : (m == 2'h1) ? 4'h3 : (m == 2'h2) ? 4'hC : 4'hF;
    return {5'h00, p, 1'b0, ab, 5'h01};
  endfunction

  function automatic logic [15:0] wm(input int i);
    case (i)
      3: return 16'hFFFF;
      4: return ans_pkg::ADV_WMASK;
      7: return ans_pkg::NPTX_WMASK;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Holds one request until waitrequest is seen low; leaves it raised.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] wd, output logic [15:0] q);
    int n;
    n = 0;
    req.avs_read <= !wr;
    req.avs_write <= wr;
    req.avs_address <= a;
    req.avs_writedata <= {16'h0000, wd};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    q = avs_readdata[15:0];
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic idle();
    req.avs_read <= 1'b0;
    req.avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Main sequence: reset values, writes, partner events, toggle.
  initial begin
    straps = lf[1:0];
    pause_pin = lf[6];
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    exp_q = '{{OUI_T, MODEL_T, REV_T}, adv_rst(straps, pause_pin),
              16'h0001, 16'h0000, 16'h2001, 16'h2000};
    for (int i = 3; i <= 9; i++) begin
      bus(1'b0, 8'(i * 4), 16'h0000, rd);
      e = (i == 9) ? 16'h0000 : exp_q[i];
      chk("reset", e, rd);
    end
    for (int i = 3; i <= 9; i++) begin
      w = lf;
      bus(1'b1, 8'(i * 4), w, rd);
      bus(1'b0, 8'(i * 4), 16'h0000, rd);
      if (i < 9) exp_q[i] = (exp_q[i] & ~wm(i)) | (w & wm(i));
      e = (i == 9) ? 16'h0000 : exp_q[i];
      chk("write", e, rd);
    end
    idle();
    an_able <= 1'b1;
    pd_fault <= 1'b1;
    w = lf | 16'h8600;
    lp.send(1'b0, w);
    bus(1'b0, 8'h14, 16'h0000, rd);
    e = (w & ans_pkg::LP_MASK) | 16'h4000;
    chk("partner", e, rd);
    bus(1'b0, 8'h18, 16'h0000, rd);
    chk("expansion", 16'h001B, rd);
    pd_fault <= 1'b0;
    bus(1'b0, 8'h18, 16'h0000, rd);
    chk("expansion", 16'h0019, rd);
    bus(1'b0, 8'h18, 16'h0000, rd);
    chk("expansion", 16'h0009, rd);
    idle();
    w = lf;
    lp.send(1'b1, w);
    bus(1'b0, 8'h20, 16'h0000, rd);
    chk("next rx", w, rd);
    bus(1'b0, 8'h18, 16'h0000, rd);
    chk("expansion", 16'h000B, rd);
    idle();
    for (int k = 0; k < 2; k++) begin
      np_tx_sent <= 1'b1;
      @(posedge clk_sys);
      np_tx_sent <= 1'b0;
      bus(1'b0, 8'h1C, 16'h0000, rd);
      e = exp_q[7] ^ ((k == 0) ? 16'h0800 : 16'h0000);
      chk("next tx", e, rd);
      idle();
    end
    // Software reset under every mode strap setting restores the identifier and advert reset values.
    for (int m = 0; m < 4; m++) begin
      straps <= 2'(m);
      pause_pin <= lf[9];
      sw_rst <= 1'b1;
      @(posedge clk_sys);
      sw_rst <= 1'b0;
      bus(1'b0, 8'h10, 16'h0000, rd);
      chk("strap", adv_rst(straps, pause_pin), rd);
      bus(1'b0, 8'h0C, 16'h0000, rd);
      chk("sw reset", {OUI_T, MODEL_T, REV_T}, rd);
      idle();
    end
    conclude();
  end
endmodule
